//--- rtl/tss_pkg.sv
// Shared constants and types for the touch scan sequencer
package tss_pkg;
  // Clock rate expressed in MHz so that microsecond times become cycles
  localparam int unsigned CLK_MHZ            = 10;
  localparam int unsigned PRECHARGE_TIME_US  = 4;
  localparam int unsigned SENSE_TIME_US      = 4;
  localparam int unsigned PRECHARGE_CYCLES   = PRECHARGE_TIME_US * CLK_MHZ;
  localparam int unsigned SENSE_CYCLES       = SENSE_TIME_US * CLK_MHZ;
  // Panel settling choices; the longest stays below 4096 cycles
  localparam int unsigned SETTLE_TIME0_US    = 10;
  localparam int unsigned SETTLE_TIME1_US    = 100;
  localparam int unsigned SETTLE_TIME2_US    = 200;
  localparam int unsigned SETTLE_TIME3_US    = 400;
  localparam int unsigned TIMER_W            = 12;

  // Register map: page bit and address
  localparam logic       PAGE_DATA           = 1'b0;
  localparam logic       PAGE_CTRL           = 1'b1;
  localparam logic [4:0] ADDR_X              = 5'h00;
  localparam logic [4:0] ADDR_Y              = 5'h01;
  localparam logic [4:0] ADDR_PRESSURE_A     = 5'h02;
  localparam logic [4:0] ADDR_PRESSURE_B     = 5'h03;
  localparam logic [4:0] ADDR_KEYPAD_STATE   = 5'h04;
  localparam logic [4:0] ADDR_CONTRAST_DAC   = 5'h0b;
  localparam logic [4:0] ADDR_SCAN_CONFIG    = 5'h00;

  localparam logic [15:0] DATA_RESET         = 16'h0000;
  localparam logic [7:0]  CONTRAST_RESET     = 8'h80;
  localparam logic [15:0] SCAN_CONFIG_RESET  = 16'h0000;
  localparam int unsigned CFG_START_BIT      = 6;
  localparam int unsigned CFG_BUSY_BIT       = 3;

  typedef enum logic [1:0] {
    MODE_SELF      = 2'b00,
    MODE_HOST_INIT = 2'b01,
    MODE_HOST_CTL  = 2'b10,
    MODE_RSVD      = 2'b11
  } tss_mode_t;

  typedef enum logic [1:0] {
    STAGE_Y          = 2'b00,
    STAGE_X          = 2'b01,
    STAGE_PRESSURE_A = 2'b10,
    STAGE_PRESSURE_B = 2'b11
  } tss_stage_t;

  // Scan configuration word as stored
  typedef struct packed {
    tss_mode_t  mode;
    logic       scanPressure;
    logic [1:0] resolution;
    logic [1:0] averageCount;
    logic [1:0] settleSel;
    logic       start;
    logic [1:0] hostDrive;
    logic       busy;
    logic [2:0] spare;
  } tss_cfg_t;

  typedef struct packed {
    logic yEn;
    logic xEn;
    logic zEn;
  } tss_drive_t;

  // Keep only the converted bits, right-justified
  function automatic logic [11:0] rjust(input logic [11:0] d, input logic [1:0] res);
    unique case (res)
      2'b01:   rjust = {4'h0, d[7:0]};
      2'b10:   rjust = {2'b00, d[9:0]};
      default: rjust = d;
    endcase
  endfunction
endpackage

//--- rtl/tss_avg_conv.sv
// Averaging conversion engine: issues converter starts and averages results
`timescale 1ns/1ps
module tss_avg_conv
  import tss_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire logic [1:0]  averageCount,
  input  wire logic [1:0]  resolution,
  input  wire logic        adcDone,
  input  wire logic [11:0] adcData,
  output logic             adcStart,
  output logic             done,
  output logic [11:0]      result
);
  import tss_pkg::*;

  logic        busy;
  logic [4:0]  left;
  logic [15:0] acc;
  logic [15:0] next_acc;
  logic [1:0]  shift;
  logic [4:0]  total;

  always_comb begin
    unique case (averageCount)
      2'b01:   begin total = 5'd4;  shift = 2'd2; end
      2'b10:   begin total = 5'd8;  shift = 2'd3; end
      2'b11:   begin total = 5'd16; shift = 2'd0; end
      default: begin total = 5'd1;  shift = 2'd0; end
    endcase
    next_acc = acc + {4'h0, rjust(adcData, resolution)};
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      busy     <= 1'b0;
      left     <= 5'd0;
      acc      <= 16'h0000;
      adcStart <= 1'b0;
      done     <= 1'b0;
      result   <= 12'h000;
    end else begin
      adcStart <= 1'b0;
      done     <= 1'b0;
      if (start) begin
        busy     <= 1'b1;
        left     <= total;
        acc      <= 16'h0000;
        adcStart <= 1'b1;
      end else if (busy && adcDone) begin
        acc <= next_acc;
        if (left == 5'd1) begin
          // Only the final average leaves the engine
          busy <= 1'b0;
          done <= 1'b1;
          if (averageCount == 2'b11) begin
            result <= next_acc[15:4];
          end else begin
            result <= 12'(next_acc >> shift);
          end
        end else begin
          left     <= left - 5'd1;
          adcStart <= 1'b1;
        end
      end
    end
  end
endmodule // tss_avg_conv

//--- rtl/tss_scan_seq.sv
// Touch scan sequencer top: scan control, result and keypad/DAC registers
//
// Behaviour
// - Results stored right-justified, upper bits zero
// - Reset clears data registers, DAC loads midscale
// - DAC code in low byte, upper reserved
// - Keypad register has one bit per key
// - Self, host-initiated and host-controlled modes offered
// - Touch drives interrupt low, clock powers up in self mode (code holds interrupt high in MODE_RSVD)
// - Drive Y, settle, power converter, convert Y
// - Averaging stores only final averaged value
// - Convert X only if still touched
// - X/Y scan ends after X stored
// - Pressure scan adds both pressure samples
// - X/Y scan time follows settle and conversion
// - Pressure scan time adds third settle phase
// - Ready idles high, low while unread data
// - Keypad bits equal keys found pressed
`timescale 1ns/1ps
module tss_scan_seq
  import tss_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        penTouched,
  input  wire logic        adcDone,
  input  wire logic [11:0] adcData,
  input  wire logic        keyScanValid,
  input  wire logic [15:0] keyScanBits,
  input  wire logic        regPage,
  input  wire logic [4:0]  regAddr,
  input  wire logic        regWr,
  input  wire logic        regRd,
  input  wire logic [15:0] regWdata,
  output logic [15:0]      regRdata,
  output logic             touchDetectIrqN,
  output logic             resultReadyN,
  output logic             convClockOn,
  output logic             adcPowerOn,
  output tss_drive_t       panelDrive,
  output logic             adcStart,
  output logic [7:0]       contrastCode
);
  import tss_pkg::*;

  typedef enum logic [1:0] {
    S_IDLE   = 2'b00,
    S_SETTLE = 2'b01,
    S_CONV   = 2'b10,
    S_NEXT   = 2'b11
  } tss_state_t;

  tss_state_t         state;
  tss_stage_t         stage;
  tss_cfg_t           cfg;
  logic [TIMER_W-1:0] timer;
  logic [TIMER_W-1:0] settleLoad;
  logic [11:0]        result [4];
  logic [15:0]        keypadKeyState;
  logic [4:0]         unread;
  logic [4:0]         next_unread;
  logic [4:0]         readHit;
  logic               convKick;
  logic               avgDone;
  logic [11:0]        avgResult;
  logic               scanStart;
  logic               dataRd;

  assign dataRd = regRd && (regPage == PAGE_DATA);

  // Settle, precharge and sense all elapse before every conversion except STAGE_PRESSURE_B
  always_comb begin
    unique case (cfg.settleSel)
      2'b00: settleLoad = TIMER_W'(SETTLE_TIME0_US * CLK_MHZ + PRECHARGE_CYCLES + SENSE_CYCLES);
      2'b01: settleLoad = TIMER_W'(SETTLE_TIME1_US * CLK_MHZ + PRECHARGE_CYCLES + SENSE_CYCLES);
      2'b10: settleLoad = TIMER_W'(SETTLE_TIME2_US * CLK_MHZ + PRECHARGE_CYCLES + SENSE_CYCLES);
      2'b11: settleLoad = TIMER_W'(SETTLE_TIME3_US * CLK_MHZ + PRECHARGE_CYCLES + SENSE_CYCLES);
    endcase
  end

  // A host start request is honoured only while the panel is touched
  always_comb begin
    unique case (cfg.mode)
      MODE_SELF:      scanStart = penTouched;
      MODE_HOST_INIT: scanStart = penTouched && regWr && regPage == PAGE_CTRL
                                  && regAddr == ADDR_SCAN_CONFIG
                                  && regWdata[CFG_START_BIT];
      default:        scanStart = 1'b0;
    endcase
  end

  // Scan sequencer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state       <= S_IDLE;
      stage       <= STAGE_Y;
      timer       <= '0;
      convClockOn <= 1'b0;
      adcPowerOn  <= 1'b0;
      panelDrive  <= '0;
      convKick    <= 1'b0;
    end else begin
      convKick <= 1'b0;
      unique case (state)
        S_IDLE: begin
          adcPowerOn <= 1'b0;
          if (scanStart && state == S_IDLE && cfg.mode != MODE_HOST_CTL) begin
            convClockOn <= 1'b1;
            stage       <= STAGE_Y;
            panelDrive  <= '{yEn: 1'b1, xEn: 1'b0, zEn: 1'b0};
            timer       <= settleLoad;
            state       <= S_SETTLE;
          end else begin
            convClockOn <= 1'b0;
            // In host-controlled mode the drivers follow the host directly
            if (cfg.mode == MODE_HOST_CTL) begin
              panelDrive <= '{yEn: cfg.hostDrive == 2'b01, xEn: cfg.hostDrive == 2'b10,
                              zEn: cfg.hostDrive == 2'b11};
            end else begin
              panelDrive <= '0;
            end
          end
        end
        S_SETTLE: begin
          if (stage == STAGE_Y && !penTouched) begin
            state      <= S_IDLE;
            panelDrive <= '0;
          end else if (timer == '0) begin
            adcPowerOn <= 1'b1;
            convKick   <= 1'b1;
            state      <= S_CONV;
          end else begin
            timer <= timer - TIMER_W'(1);
          end
        end
        S_CONV: begin
          if (avgDone) begin
            state <= S_NEXT;
          end
        end
        S_NEXT: begin
          adcPowerOn <= 1'b0;
          timer      <= settleLoad;
          state      <= S_SETTLE;
          unique case (stage)
            STAGE_Y: begin
              if (penTouched) begin
                stage      <= STAGE_X;
                panelDrive <= '{yEn: 1'b0, xEn: 1'b1, zEn: 1'b0};
              end else begin
                state      <= S_IDLE;
                panelDrive <= '0;
              end
            end
            STAGE_X: begin
              if (cfg.scanPressure) begin
                stage      <= STAGE_PRESSURE_A;
                panelDrive <= '{yEn: 1'b0, xEn: 1'b0, zEn: 1'b1};
              end else begin
                state      <= S_IDLE;
                panelDrive <= '0;
              end
            end
            STAGE_PRESSURE_A: begin
              // Both pressure samples share one settle phase
              stage <= STAGE_PRESSURE_B;
              timer <= '0;
            end
            STAGE_PRESSURE_B: begin
              state      <= S_IDLE;
              panelDrive <= '0;
            end
          endcase
        end
      endcase
    end
  end

  tss_avg_conv u_tss_avg_conv (
    .clk          (clk),
    .rst_b        (rst_b),
    .start        (convKick),
    .averageCount (cfg.averageCount),
    .resolution   (cfg.resolution),
    .adcDone      (adcDone),
    .adcData      (adcData),
    .adcStart     (adcStart),
    .done         (avgDone),
    .result       (avgResult)
  );

  // Pen interrupt follows the touch as long as the panel is watched
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      touchDetectIrqN <= 1'b1;
    end else begin
      touchDetectIrqN <= !(penTouched && cfg.mode != MODE_RSVD);
    end
  end

  // Result registers, indexed by stage
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        result[i] <= 12'h000;
      end
    end else if (state == S_CONV && avgDone) begin
      result[stage] <= avgResult;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      keypadKeyState <= DATA_RESET;
    end else if (keyScanValid) begin
      keypadKeyState <= keyScanBits;
    end
  end

  // Control and DAC registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      contrastCode <= CONTRAST_RESET;
      cfg          <= SCAN_CONFIG_RESET;
    end else if (regWr) begin
      if (regPage == PAGE_DATA && regAddr == ADDR_CONTRAST_DAC) begin
        contrastCode <= regWdata[7:0];
      end
      if (regPage == PAGE_CTRL && regAddr == ADDR_SCAN_CONFIG) begin
        cfg       <= regWdata;
        cfg.start <= 1'b0;
        cfg.busy  <= 1'b0;
        cfg.spare <= 3'b000;
      end
    end
  end

  // Unread tracking; a store in the same cycle as its read keeps the flag
  always_comb begin
    readHit = '0;
    // Flags are indexed by stage, which orders Y before X unlike the address map
    if (dataRd) begin
      unique case (regAddr)
        ADDR_X:            readHit[STAGE_X] = 1'b1;
        ADDR_Y:            readHit[STAGE_Y] = 1'b1;
        ADDR_PRESSURE_A:   readHit[STAGE_PRESSURE_A] = 1'b1;
        ADDR_PRESSURE_B:   readHit[STAGE_PRESSURE_B] = 1'b1;
        ADDR_KEYPAD_STATE: readHit[4] = 1'b1;
        default:           readHit = '0;
      endcase
    end
    next_unread = unread & ~readHit;
    if (state == S_CONV && avgDone) begin
      next_unread[stage] = 1'b1;
    end
    if (keyScanValid) begin
      next_unread[4] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      unread       <= '0;
      resultReadyN <= 1'b1;
    end else begin
      unread       <= next_unread;
      resultReadyN <= ~|next_unread;
    end
  end

  // Read port answers one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      regRdata <= 16'h0000;
    end else if (regRd) begin
      regRdata <= 16'h0000;
      if (regPage == PAGE_DATA) begin
        unique case (regAddr)
          ADDR_X:            regRdata <= {4'h0, result[STAGE_X]};
          ADDR_Y:            regRdata <= {4'h0, result[STAGE_Y]};
          ADDR_PRESSURE_A:   regRdata <= {4'h0, result[STAGE_PRESSURE_A]};
          ADDR_PRESSURE_B:   regRdata <= {4'h0, result[STAGE_PRESSURE_B]};
          ADDR_KEYPAD_STATE: regRdata <= keypadKeyState;
          ADDR_CONTRAST_DAC: regRdata <= {8'h00, contrastCode};
          default:           regRdata <= 16'h0000;
        endcase
      end else if (regAddr == ADDR_SCAN_CONFIG) begin
        regRdata                <= cfg;
        regRdata[CFG_BUSY_BIT]  <= state != S_IDLE;
      end
    end
  end
endmodule // tss_scan_seq

//--- tb/tss_scan_seq_monitor.sv
// Port assertions for the touch scan sequencer
`timescale 1ns/1ps
module tss_scan_seq_monitor
  import tss_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        penTouched,
  input wire logic        keyScanValid,
  input wire logic        regPage,
  input wire logic [4:0]  regAddr,
  input wire logic        regRd,
  input wire logic        regWr,
  input wire logic [15:0] regWdata,
  input wire logic [15:0] regRdata,
  input wire logic        touchDetectIrqN,
  input wire logic        resultReadyN,
  input wire logic        convClockOn,
  input wire logic        adcPowerOn,
  input wire tss_drive_t  panelDrive,
  input wire logic        adcStart,
  input wire logic [7:0]  contrastCode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // Mode mirror: idle drive differs in host-controlled mode, the clock on a pen interrupt outside self mode
  tss_cfg_t  cfgWord;
  tss_mode_t modeSeen;
  assign cfgWord = regWdata;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      modeSeen <= MODE_SELF;
    end else if (regWr && regPage == PAGE_CTRL && regAddr == ADDR_SCAN_CONFIG) begin
      modeSeen <= cfgWord.mode;
    end
  end

  sequence rdResult;
    $past(regRd) && !$past(regPage) && $past(regAddr) < 5'h04;
  endsequence
  sequence settleStart;
    $rose(panelDrive.yEn);
  endsequence

  chk_result_upper: assert property (rdResult |-> regRdata[15:12] == 4'h0)
    else $error("result word upper bits set");
  chk_dac_upper: assert property ($past(regRd) && !$past(regPage)
    && $past(regAddr) == ADDR_CONTRAST_DAC |-> regRdata == {8'h00, contrastCode})
    else $error("dac word wrong");
  chk_reset_state: assert property ($rose(rst_b) |-> contrastCode == 8'h80
    && resultReadyN && touchDetectIrqN && !convClockOn)
    else $error("reset state wrong");
  chk_touch_irq: assert property (penTouched |=> !touchDetectIrqN)
    else $error("pen interrupt not low");
  chk_irq_clock: assert property ($fell(touchDetectIrqN) && modeSeen == MODE_SELF
    |-> convClockOn)
    else $error("clock not on with interrupt");
  chk_start_powered: assert property (adcStart |-> adcPowerOn)
    else $error("start without converter power");
  chk_settle_gap: assert property (settleStart |-> !adcPowerOn [*8])
    else $error("no settle wait");
  chk_x_touched: assert property ($rose(panelDrive.xEn) |-> $past(penTouched))
    else $error("x drive while untouched");
  chk_idle_quiet: assert property (!convClockOn && !$past(convClockOn)
    && modeSeen != MODE_HOST_CTL && $past(modeSeen) != MODE_HOST_CTL
    |-> panelDrive == 3'b000 && !adcPowerOn)
    else $error("drive active while idle");
  chk_key_ready: assert property (keyScanValid |-> ##[1:3] !resultReadyN)
    else $error("ready not low after key scan");
endmodule // tss_scan_seq_monitor

bind tss_scan_seq tss_scan_seq_monitor u_tss_scan_seq_monitor (
  .clk(clk), .rst_b(rst_b), .penTouched(penTouched), .keyScanValid(keyScanValid),
  .regPage(regPage), .regAddr(regAddr), .regRd(regRd), .regRdata(regRdata),
  .regWr(regWr), .regWdata(regWdata),
  .touchDetectIrqN(touchDetectIrqN), .resultReadyN(resultReadyN),
  .convClockOn(convClockOn), .adcPowerOn(adcPowerOn), .panelDrive(panelDrive),
  .adcStart(adcStart), .contrastCode(contrastCode)
);

//--- tb/tss_adc_model.sv
// Converter model answering each start pulse after a fixed latency
`timescale 1ns/1ps
module tss_adc_model #(
  parameter int LAT = 6
) (
  input  wire logic        clk,
  input  wire logic        adcStart,
  input  wire logic [11:0] base,
  input  wire logic        wobble,
  output logic             adcDone,
  output logic [11:0]      adcData
);
  int   cnt = 0;
  logic odd = 1'b0;
  // Data is only valid with the done pulse; otherwise it shows junk
  always @(posedge clk) begin
    adcDone <= 1'b0;
    adcData <= ~base;
    if (adcStart) cnt <= LAT;
    else if (cnt > 0) cnt <= cnt - 1;
    if (cnt == 1) begin
      adcDone <= 1'b1;
      adcData <= (wobble && odd) ? base + 12'h002 : base;
      odd     <= !odd;
    end
  end
endmodule // tss_adc_model

//--- tb/test_tss_scan_seq.sv
// Self-checking bench for the touch scan sequencer
`timescale 1ns/1ps
module test_tss_scan_seq;
  import tss_pkg::*;
  localparam int LAT = 6;
  logic        clk          = 1'b0;
  logic        rst_b        = 1'b0;
  logic        penTouched   = 1'b0;
  logic        keyScanValid = 1'b0;
  logic [15:0] keyScanBits  = 16'h0000;
  logic        regPage      = 1'b0;
  logic [4:0]  regAddr      = 5'h00;
  logic        regWr        = 1'b0;
  logic        regRd        = 1'b0;
  logic [15:0] regWdata     = 16'h0000;
  logic [11:0] base         = 12'h0abc;
  logic        wobble       = 1'b0;
  logic        adcDone, touchDetectIrqN, resultReadyN, convClockOn, adcPowerOn, adcStart;
  logic [11:0] adcData;
  logic [15:0] regRdata, rd;
  logic [7:0]  contrastCode;
  tss_drive_t  panelDrive;
  int          err_count = 0;
  int          cmp_count = 0;
  int          n, k;
  always #50 clk = ~clk;

  tss_scan_seq u_tss_scan_seq (.clk(clk), .rst_b(rst_b), .penTouched(penTouched),
    .adcDone(adcDone), .adcData(adcData), .keyScanValid(keyScanValid),
    .keyScanBits(keyScanBits), .regPage(regPage), .regAddr(regAddr), .regWr(regWr),
    .regRd(regRd), .regWdata(regWdata), .regRdata(regRdata),
    .touchDetectIrqN(touchDetectIrqN), .resultReadyN(resultReadyN),
    .convClockOn(convClockOn), .adcPowerOn(adcPowerOn), .panelDrive(panelDrive),
    .adcStart(adcStart), .contrastCode(contrastCode));
  tss_adc_model #(.LAT(LAT)) u_tss_adc_model (.clk(clk), .adcStart(adcStart),
    .base(base), .wobble(wobble), .adcDone(adcDone), .adcData(adcData));

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic tick(input int c = 1);
    repeat (c) @(negedge clk);
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic guard(input int c);
    if (c >= 3000) begin
      check("wait bound", 16'h0000, 16'h0001);
      test_done();
    end
  endtask
  // One strobe cycle, then a quiet cycle so strobes never meet back to back
  task automatic access(input logic pg, input logic [4:0] a, input logic wr,
                        input logic [15:0] d);
    regPage  = pg;
    regAddr  = a;
    regWr    = wr;
    regRd    = !wr;
    regWdata = d;
    tick();
    regWr = 1'b0;
    regRd = 1'b0;
    rd    = regRdata;
    tick();
  endtask
  task automatic waitIdle;
    for (n = 0; n < 3000 && convClockOn; n++) tick();
    guard(n);
  endtask

  task automatic t_reset;
    for (int a = 0; a < 5; a++) begin
      access(PAGE_DATA, 5'(a), 1'b0, 16'h0000);
      check("data reg", DATA_RESET, rd);
    end
    access(PAGE_DATA, ADDR_CONTRAST_DAC, 1'b0, 16'h0000);
    check("dac reset", 16'h0080, rd);
    access(PAGE_DATA, 5'h1f, 1'b0, 16'h0000);
    check("unmapped", 16'h0000, rd);
    $display("test reset done");
  endtask
  task automatic t_regs;
    access(PAGE_DATA, ADDR_CONTRAST_DAC, 1'b1, 16'habcd);
    access(PAGE_DATA, ADDR_CONTRAST_DAC, 1'b0, 16'h0000);
    check("dac word", 16'h00cd, rd);
    check("dac out", 16'h00cd, {8'h00, contrastCode});
    access(PAGE_DATA, ADDR_KEYPAD_STATE, 1'b1, 16'hffff);
    access(PAGE_DATA, ADDR_KEYPAD_STATE, 1'b0, 16'h0000);
    check("keypad ro", 16'h0000, rd);
    access(PAGE_CTRL, ADDR_SCAN_CONFIG, 1'b1, 16'h8030);
    check("host drive", 16'h0001, {13'h0000, panelDrive});
    access(PAGE_CTRL, ADDR_SCAN_CONFIG, 1'b0, 16'h0000);
    check("cfg word", 16'h8030, rd);
    access(PAGE_CTRL, ADDR_SCAN_CONFIG, 1'b1, 16'h0000);
    check("drive off", 16'h0000, {13'h0000, panelDrive});
    $display("test regs done");
  endtask
  task automatic t_keypad;
    keyScanBits  = 16'h2140;
    keyScanValid = 1'b1;
    tick();
    keyScanValid = 1'b0;
    for (n = 0; n < 3000 && resultReadyN; n++) tick();
    guard(n);
    access(PAGE_DATA, ADDR_KEYPAD_STATE, 1'b0, 16'h0000);
    check("keypad", 16'h2140, rd);
    check("ready high", 16'h0001, {15'h0000, resultReadyN});
    $display("test keypad done");
  endtask
  task automatic t_xy;
    penTouched = 1'b1;
    tick(2);
    check("irq", 16'h0000, {15'h0000, touchDetectIrqN});
    check("clock", 16'h0001, {15'h0000, convClockOn});
    for (n = 2; n < 3000 && !panelDrive.xEn; n++) tick();
    for (; n < 3000 && panelDrive.xEn; n++) tick();
    guard(n);
    penTouched = 1'b0;
    check("xy time", 16'h0001, {15'h0000, n >= 360 && n <= 445 + 2 * LAT});
    waitIdle();
    access(PAGE_DATA, ADDR_Y, 1'b0, 16'h0000);
    check("y", 16'h0abc, rd);
    access(PAGE_DATA, ADDR_X, 1'b0, 16'h0000);
    check("x", 16'h0abc, rd);
    check("ready high", 16'h0001, {15'h0000, resultReadyN});
    $display("test xy done");
  endtask
  task automatic t_pressure;
    access(PAGE_CTRL, ADDR_SCAN_CONFIG, 1'b1, 16'h2a00);
    base       = 12'h5a4;
    wobble     = 1'b1;
    penTouched = 1'b1;
    k = 0;
    for (n = 0; n < 3000 && k < 16; n++) begin
      tick();
      k += int'(adcDone);
    end
    guard(n);
    check("xyz time", 16'h0001, {15'h0000, n >= 540 && n <= 944 + 16 * LAT});
    tick(3);
    penTouched = 1'b0;
    waitIdle();
    for (int a = 0; a < 4; a++) begin
      access(PAGE_DATA, 5'(a), 1'b0, 16'h0000);
      check("avg result", 16'h00a5, rd);
    end
    $display("test pressure done");
  endtask
  task automatic t_release;
    access(PAGE_CTRL, ADDR_SCAN_CONFIG, 1'b1, 16'h0000);
    base       = 12'h123;
    wobble     = 1'b0;
    penTouched = 1'b1;
    tick(20);
    penTouched = 1'b0;
    tick(3);
    check("settle abort", 16'h0000, {15'h0000, convClockOn});
    check("no new data", 16'h0001, {15'h0000, resultReadyN});
    penTouched = 1'b1;
    for (n = 0; n < 3000 && !adcDone; n++) tick();
    guard(n);
    penTouched = 1'b0;
    k = 0;
    for (n = 0; n < 400; n++) begin
      tick();
      k |= int'(panelDrive.xEn);
    end
    check("no x", 16'h0000, 16'(k));
    check("idle", 16'h0000, {15'h0000, convClockOn});
    access(PAGE_DATA, ADDR_Y, 1'b0, 16'h0000);
    check("y kept", 16'h0123, rd);
    check("ready high", 16'h0001, {15'h0000, resultReadyN});
    access(PAGE_CTRL, ADDR_SCAN_CONFIG, 1'b1, 16'h4000);
    penTouched = 1'b1;
    tick(5);
    check("no self start", 16'h0000, {15'h0000, convClockOn});
    access(PAGE_CTRL, ADDR_SCAN_CONFIG, 1'b1, 16'h4040);
    check("host start", 16'h0001, {15'h0000, convClockOn});
    penTouched = 1'b0;
    waitIdle();
    $display("test release done");
  endtask

  initial begin
    tick(6);
    rst_b = 1'b1;
    tick();
    t_reset();
    t_regs();
    t_keypad();
    t_xy();
    t_pressure();
    t_release();
    test_done();
  end
endmodule // test_tss_scan_seq
